// >>> inc/tmoc_params.svh
// register offsets, field positions, top values and mode and action codes of the timer compare block
`ifndef TMOC_PARAMS_SVH
`define TMOC_PARAMS_SVH

`define TMOC_ADDR_W        4
`define TMOC_OFS_CNT_LO    4'h0
`define TMOC_OFS_CNT_HI    4'h1
`define TMOC_OFS_CMPA_LO   4'h2
`define TMOC_OFS_CMPA_HI   4'h3
`define TMOC_OFS_CMPB_LO   4'h4
`define TMOC_OFS_CMPB_HI   4'h5
`define TMOC_OFS_CTRL_A    4'h6
`define TMOC_OFS_CTRL_B    4'h7
`define TMOC_OFS_FLAGS     4'h8
`define TMOC_OFS_STATUS    4'h9

// control a: [7:6] action a, [5:4] action b, [3:0] waveform generation select
`define TMOC_CA_WGM_LSB    0
`define TMOC_CA_ACTB_LSB   4
`define TMOC_CA_ACTA_LSB   6
// control b: [0] force a, [1] force b, [2] irq en a, [3] irq en b, [4] irq en overflow
`define TMOC_CB_FORCE_LSB  0
`define TMOC_CB_IEN_LSB    2
// flags: [0] match a, [1] match b, [2] overflow
`define TMOC_FLAG_OVF      2

`define TMOC_MAX           16'hFFFF
`define TMOC_BOTTOM        16'h0000
`define TMOC_TOP_8BIT      16'h00FF
`define TMOC_TOP_9BIT      16'h01FF
`define TMOC_TOP_10BIT     16'h03FF

`define TMOC_WGM_NORMAL    4'h0
`define TMOC_WGM_CTC_CMP   4'h4
`define TMOC_WGM_CTC_CAP   4'hC
`define TMOC_WGM_RESERVED  4'hD
`define TMOC_WGM_FPWM_CMPA 4'hF

`define TMOC_ACT_NONE      2'h0
`define TMOC_ACT_TOGGLE    2'h1
`define TMOC_ACT_CLEAR     2'h2
`define TMOC_ACT_SET       2'h3

`endif

// >>> inc/tmoc_pkg.sv
// types shared by the timer compare block
package tmoc_pkg;
  typedef logic [1:0] tmoc_act_t;
  typedef logic [3:0] tmoc_wgm_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmoc_bus_s;

  // pin interface toward the general port logic
  typedef struct packed {
    logic [1:0] port_out;
    logic [1:0] port_dir;
  } tmoc_port_s;

  // whole block state
  typedef struct packed {
    logic [15:0]      count;
    logic [7:0]       temp;
    logic [1:0][15:0] cmp;
    logic [1:0][15:0] cbuf;
    logic [1:0][1:0]  act;
    tmoc_wgm_t        wgm;
    logic [2:0]       ien;
    logic [2:0]       flag;
    logic [1:0]       wave;
    logic             block;
    logic [7:0]       rdata;
  } tmoc_state_s;
endpackage

// >>> rtl/tmoc_top.sv
// output compare units and counter of a 16-bit timer with 8-bit register port
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "tmoc_params.svh"

// Contract
// - counter compared to each compare value; equality sets flag next timer tick
// - enabled flag requests interrupt; cleared by service or writing one
// - compare unit a can set the counter top value
// - compare value double buffered in pwm modes, updated at top
// - cpu reaches buffer when buffered, compare directly otherwise; timer never alters it
// - compare high byte reads directly, not through the temporary byte
// - high byte goes to temporary; low write moves it into upper byte
// - force strobe in non-pwm modes acts like match without flag or clear
// - counter write blocks compare matches in the next timer tick
// - loading top in variable-top mode loses top match; counts to 0xFFFF
// - waveform output keeps its value across mode changes
// - action bits unbuffered; govern next match; force applies them at once
// - reset clears each waveform output to zero
// - nonzero action bits route waveform to pin; direction still from port
// - action bits have no influence on capture function
// - action zero leaves waveform output unchanged on matches
// - counting set only by mode bits; action bits pick output behaviour
// - mode zero increments always, wrapping 0xFFFF to 0x0000
// - normal mode overflow flag set when counter becomes zero
// - normal mode accepts a counter write at any time
// - cpu counter write wins over timer count or clear in same cycle
module tmoc_top (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire tmoc_pkg::tmoc_bus_s     i_bus,
  output logic [7:0]                   o_rdata,
  input  wire logic                    i_tick,
  input  wire logic [15:0]             i_capture_value,
  input  wire logic [2:0]              i_irq_ack,
  output logic [2:0]                   o_irq,
  input  wire tmoc_pkg::tmoc_port_s    i_port,
  output logic [1:0]                   o_pin_out,
  output logic [1:0]                   o_pin_oe_n,
  output logic [1:0]                   o_waveform_out
);
  import tmoc_pkg::*;

  tmoc_state_s st_reg;
  tmoc_state_s st_next;

  // the twelve pwm modes are all but normal, the two ctc modes and reserved
  function automatic logic is_pwm(input tmoc_wgm_t w);
    is_pwm = !(w == `TMOC_WGM_NORMAL || w == `TMOC_WGM_CTC_CMP ||
               w == `TMOC_WGM_CTC_CAP || w == `TMOC_WGM_RESERVED);
  endfunction

  // modes that clear the counter at some top value
  function automatic logic has_top(input tmoc_wgm_t w);
    has_top = !(w == `TMOC_WGM_NORMAL || w == `TMOC_WGM_RESERVED);
  endfunction

  // top value per mode; unit a serves as top in modes 4, 9, 11, 15
  function automatic logic [15:0] top_of(input tmoc_wgm_t w, input logic [15:0] cmp_a,
                                         input logic [15:0] cap);
    case (w)
      4'h1, 4'h5: top_of = `TMOC_TOP_8BIT;
      4'h2, 4'h6: top_of = `TMOC_TOP_9BIT;
      4'h3, 4'h7: top_of = `TMOC_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = cmp_a;
      4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
      default: top_of = `TMOC_MAX;
    endcase
  endfunction

  // address decode of the compare byte locations; low byte used for read and write, high byte for read only
  function automatic logic is_cmp_lo(input logic [3:0] a, input int u);
    is_cmp_lo = (u == 0) ? (a == `TMOC_OFS_CMPA_LO) : (a == `TMOC_OFS_CMPB_LO);
  endfunction

  function automatic logic is_cmp_hi(input logic [3:0] a, input int u);
    is_cmp_hi = (u == 0) ? (a == `TMOC_OFS_CMPA_HI) : (a == `TMOC_OFS_CMPB_HI);
  endfunction

  // output action of one unit on a match
  function automatic logic act_match(input logic cur, input logic [1:0] act,
                                     input logic pwm);
    if (pwm) begin
      case (act)
        `TMOC_ACT_CLEAR: act_match = 1'b1;
        `TMOC_ACT_SET:   act_match = 1'b0;
        default:         act_match = cur;
      endcase
    end else begin
      case (act)
        `TMOC_ACT_TOGGLE: act_match = ~cur;
        `TMOC_ACT_CLEAR:  act_match = 1'b0;
        `TMOC_ACT_SET:    act_match = 1'b1;
        default:          act_match = cur;
      endcase
    end
  endfunction

  // decoded strobes and combinational status
  logic        cnt_wr;
  logic        pwm;
  logic        at_top;
  logic [15:0] top_val;
  logic [1:0]  match;
  logic [1:0]  force_cmp;

  always_comb begin
    pwm     = is_pwm(st_reg.wgm);
    top_val = top_of(st_reg.wgm, st_reg.cmp[0], i_capture_value);
    cnt_wr  = i_bus.wr && i_bus.addr == `TMOC_OFS_CNT_LO;
    // a counter write in the previous timer cycle hides top and matches
    at_top  = has_top(st_reg.wgm) && st_reg.count == top_val && !st_reg.block;
    for (int u = 0; u < 2; u++) begin
      match[u]     = i_tick && st_reg.count == st_reg.cmp[u] && !st_reg.block;
      force_cmp[u] = i_bus.wr && i_bus.addr == `TMOC_OFS_CTRL_B &&
                     i_bus.wdata[`TMOC_CB_FORCE_LSB + u] && !pwm;
    end
  end

  // next state: counter, compare registers, flags, waveform and read data
  always_comb begin
    st_next = st_reg;
    // counter: count and clear on the timer tick only
    if (i_tick) begin
      if (at_top) begin
        st_next.count = `TMOC_BOTTOM;
      end else begin
        st_next.count = 16'(st_reg.count + 16'h0001);
      end
      st_next.block = 1'b0;
    end
    // overflow: at max in normal and ctc, at top in pwm modes
    if (i_tick && ((pwm && at_top) || (!pwm && st_reg.count == `TMOC_MAX))) begin
      st_next.flag[`TMOC_FLAG_OVF] = 1'b1;
    end
    // double buffer transfer at top in pwm modes
    if (i_tick && pwm && at_top) begin
      st_next.cmp = st_reg.cbuf;
    end
    // waveform generation; mode changes do not touch the output register
    for (int u = 0; u < 2; u++) begin
      if (match[u]) begin
        st_next.wave[u] = act_match(st_reg.wave[u], st_reg.act[u], pwm);
      end
      if (i_tick && pwm && at_top && !match[u]) begin
        if (st_reg.act[u] == `TMOC_ACT_CLEAR) begin
          st_next.wave[u] = 1'b0;
        end else if (st_reg.act[u] == `TMOC_ACT_SET) begin
          st_next.wave[u] = 1'b1;
        end
      end
      if (force_cmp[u]) begin
        st_next.wave[u] = act_match(st_reg.wave[u], st_reg.act[u], 1'b0);
      end
    end
    // cpu writes
    if (i_bus.wr) begin
      case (i_bus.addr)
        `TMOC_OFS_CNT_HI,
        `TMOC_OFS_CMPA_HI,
        `TMOC_OFS_CMPB_HI: st_next.temp = i_bus.wdata;
        `TMOC_OFS_CNT_LO: begin
          st_next.count = {st_reg.temp, i_bus.wdata};
          st_next.block = 1'b1;
        end
        `TMOC_OFS_CTRL_A: begin
          st_next.wgm    = i_bus.wdata[`TMOC_CA_WGM_LSB +: 4];
          st_next.act[0] = i_bus.wdata[`TMOC_CA_ACTA_LSB +: 2];
          st_next.act[1] = i_bus.wdata[`TMOC_CA_ACTB_LSB +: 2];
        end
        `TMOC_OFS_CTRL_B: st_next.ien = i_bus.wdata[`TMOC_CB_IEN_LSB +: 3];
        default: ;
      endcase
      for (int u = 0; u < 2; u++) begin
        if (is_cmp_lo(i_bus.addr, u)) begin
          if (pwm) begin
            st_next.cbuf[u] = {st_reg.temp, i_bus.wdata};
          end else begin
            st_next.cmp[u]  = {st_reg.temp, i_bus.wdata};
            st_next.cbuf[u] = {st_reg.temp, i_bus.wdata};
          end
        end
      end
    end
    // flag clears by service or write-one; a set in the same cycle wins
    for (int f = 0; f < 3; f++) begin
      if (i_irq_ack[f] ||
          (i_bus.wr && i_bus.addr == `TMOC_OFS_FLAGS && i_bus.wdata[f])) begin
        st_next.flag[f] = 1'b0;
      end
    end
    for (int u = 0; u < 2; u++) begin
      if (match[u]) begin
        st_next.flag[u] = 1'b1;
      end
    end
    if (i_tick && ((pwm && at_top) || (!pwm && st_reg.count == `TMOC_MAX))) begin
      st_next.flag[`TMOC_FLAG_OVF] = 1'b1;
    end
    // reads: data in the following cycle only
    st_next.rdata = 8'h00;
    if (i_bus.rd) begin
      case (i_bus.addr)
        `TMOC_OFS_CNT_LO: begin
          st_next.rdata = st_reg.count[7:0];
          st_next.temp  = st_reg.count[15:8];
        end
        `TMOC_OFS_CNT_HI: st_next.rdata = st_reg.temp;
        `TMOC_OFS_CTRL_A: st_next.rdata = {st_reg.act[0], st_reg.act[1], st_reg.wgm};
        `TMOC_OFS_CTRL_B: st_next.rdata = {3'h0, st_reg.ien, 2'h0};
        `TMOC_OFS_FLAGS:  st_next.rdata = {5'h00, st_reg.flag};
        `TMOC_OFS_STATUS: st_next.rdata = {6'h00, st_reg.wave};
        default: ;
      endcase
      for (int u = 0; u < 2; u++) begin
        if (is_cmp_lo(i_bus.addr, u)) begin
          st_next.rdata = pwm ? st_reg.cbuf[u][7:0] : st_reg.cmp[u][7:0];
        end
        if (is_cmp_hi(i_bus.addr, u)) begin
          st_next.rdata = pwm ? st_reg.cbuf[u][15:8] : st_reg.cmp[u][15:8];
        end
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs; capture input only sets top, action bits never reach it
  always_comb begin
    o_rdata        = st_reg.rdata;
    o_irq          = st_reg.flag & st_reg.ien;
    o_waveform_out = st_reg.wave;
    for (int u = 0; u < 2; u++) begin
      o_pin_out[u]  = (st_reg.act[u] != `TMOC_ACT_NONE) ? st_reg.wave[u]
                                                       : i_port.port_out[u];
      o_pin_oe_n[u] = ~i_port.port_dir[u];
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_match_flag;
    match[0] |=> st_reg.flag[0];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match a did not set flag");

  property p_irq;
    i_tick && !pwm && st_reg.count == `TMOC_MAX && st_reg.ien[2] &&
      !(i_bus.wr && i_bus.addr == `TMOC_OFS_CTRL_B) |=> o_irq[2];
  endproperty
  a_irq: assert property (p_irq) else $error("overflow gave no interrupt");

  property p_force_no_flag;
    force_cmp[0] && !st_reg.flag[0] && !match[0] |=> !st_reg.flag[0];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set flag");

  property p_block;
    st_reg.block && i_tick && !st_reg.flag[0] |=> !st_reg.flag[0];
  endproperty
  a_block: assert property (p_block) else $error("blocked match set flag");

  property p_normal_wrap;
    st_reg.wgm == `TMOC_WGM_NORMAL && i_tick && st_reg.count == `TMOC_MAX && !cnt_wr
      |=> st_reg.count == `TMOC_BOTTOM && st_reg.flag[`TMOC_FLAG_OVF];
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

  property p_cnt_write;
    cnt_wr |=> st_reg.count == {$past(st_reg.temp), $past(i_bus.wdata)};
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");

  property p_hold;
    !i_tick && !cnt_wr |=> $stable(st_reg.count);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick");

  property p_act_none;
    st_reg.act[0] == `TMOC_ACT_NONE && !force_cmp[0] && !(i_tick && at_top)
      |=> $stable(st_reg.wave[0]);
  endproperty
  a_act_none: assert property (p_act_none) else $error("wave moved with no action");

  property p_cmp_direct;
    i_bus.wr && i_bus.addr == `TMOC_OFS_CMPA_LO && !pwm
      ##1 !(i_bus.wr && i_bus.addr == `TMOC_OFS_CMPA_HI) ##1 1'b1
      |-> st_reg.cmp[0][15:8] == $past(st_reg.temp, 2);
  endproperty
  a_cmp_direct: assert property (p_cmp_direct) else $error("compare high byte wrong");

  property p_pin;
    st_reg.act[1] != `TMOC_ACT_NONE |-> o_pin_out[1] == o_waveform_out[1];
  endproperty
  a_pin: assert property (p_pin) else $error("pin override missing");

  property p_match_flag_b;
    match[1] |=> st_reg.flag[1];
  endproperty
  a_match_flag_b: assert property (p_match_flag_b) else $error("match b did not set flag");

  property p_ack_clear;
    i_irq_ack[0] && !match[0] |=> !st_reg.flag[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("service did not clear flag a");

  property p_top_clear;
    st_reg.wgm == `TMOC_WGM_FPWM_CMPA && i_tick && st_reg.count == st_reg.cmp[0] &&
      !st_reg.block && !cnt_wr |=> st_reg.count == `TMOC_BOTTOM;
  endproperty
  a_top_clear: assert property (p_top_clear) else $error("compare a top did not clear");

  property p_buf_hold;
    pwm && !(i_tick && at_top) |=> $stable(st_reg.cmp);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("compare moved between tops");

  property p_cpu_buf;
    i_bus.wr && i_bus.addr == `TMOC_OFS_CMPB_LO && pwm
      |=> st_reg.cbuf[1] == {$past(st_reg.temp), $past(i_bus.wdata)};
  endproperty
  a_cpu_buf: assert property (p_cpu_buf) else $error("buffer write lost");

  property p_cmp_hi_read;
    i_bus.rd && i_bus.addr == `TMOC_OFS_CMPA_HI && !pwm
      |=> o_rdata == $past(st_reg.cmp[0][15:8]);
  endproperty
  a_cmp_hi_read: assert property (p_cmp_hi_read) else $error("compare high read wrong");

  property p_temp_load;
    i_bus.wr && i_bus.addr == `TMOC_OFS_CMPA_HI |=> st_reg.temp == $past(i_bus.wdata);
  endproperty
  a_temp_load: assert property (p_temp_load) else $error("high byte not in temporary");

  property p_pwm_no_force;
    pwm && i_bus.wr && i_bus.addr == `TMOC_OFS_CTRL_B && !i_tick |=> $stable(st_reg.wave);
  endproperty
  a_pwm_no_force: assert property (p_pwm_no_force) else $error("force acted in pwm");

  property p_block_set;
    cnt_wr |=> st_reg.block;
  endproperty
  a_block_set: assert property (p_block_set) else $error("counter write did not block");

  property p_blocked_top;
    st_reg.block && i_tick && !cnt_wr
      |=> st_reg.count == 16'($past(st_reg.count) + 16'h0001);
  endproperty
  a_blocked_top: assert property (p_blocked_top) else $error("blocked tick cleared");

  property p_mode_keep;
    i_bus.wr && i_bus.addr == `TMOC_OFS_CTRL_A && !i_tick |=> $stable(st_reg.wave);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode change moved wave");

  property p_act_write;
    i_bus.wr && i_bus.addr == `TMOC_OFS_CTRL_A
      |=> st_reg.act[0] == $past(i_bus.wdata[`TMOC_CA_ACTA_LSB +: 2]);
  endproperty
  a_act_write: assert property (p_act_write) else $error("action a not taken");

  property p_pin_port;
    st_reg.act[0] == `TMOC_ACT_NONE |-> o_pin_out[0] == i_port.port_out[0];
  endproperty
  a_pin_port: assert property (p_pin_port) else $error("port value not on pin");

  property p_normal_count;
    st_reg.wgm == `TMOC_WGM_NORMAL && i_tick && !cnt_wr
      |=> st_reg.count == 16'($past(st_reg.count) + 16'h0001);
  endproperty
  a_normal_count: assert property (p_normal_count) else $error("normal count wrong");

  property p_ovf_keep;
    st_reg.flag[`TMOC_FLAG_OVF] && !i_irq_ack[2] &&
      !(i_bus.wr && i_bus.addr == `TMOC_OFS_FLAGS && i_bus.wdata[2]) |=> st_reg.flag[2];
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag lost");
endmodule

// >>> verification/tmoc_port_model.sv
// general port pin logic beside the compare block, with pin level
`timescale 1ns/1ps
module tmoc_port_model (
  input  wire logic [1:0]         i_dir,
  input  wire logic [1:0]         i_out,
  input  wire logic [1:0]         i_pin_out,
  input  wire logic [1:0]         i_pin_oe_n,
  output tmoc_pkg::tmoc_port_s    o_port,
  output logic [1:0]              o_pin
);
  import tmoc_pkg::*;
  // port value and direction bits handed to the block
  assign o_port = '{port_out: i_out, port_dir: i_dir};
  // a released pin is pulled up, never holds the last value
  assign o_pin = (i_pin_out & ~i_pin_oe_n) | i_pin_oe_n;
endmodule

// >>> verification/testbench.sv
// self-checking bench for the timer compare block
`timescale 1ns/1ps
`include "tmoc_params.svh"
module testbench;
  import tmoc_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  tmoc_bus_s   bus = '0;
  logic        tick = 1'b0;
  logic [2:0]  ack = 3'h0;
  logic [1:0]  dir = 2'h0;
  logic [1:0]  pout = 2'h2;
  tmoc_port_s  port;
  logic [7:0]  rdata;
  logic [7:0]  got;
  logic [2:0]  irq;
  logic [1:0]  pin_out;
  logic [1:0]  oe_n;
  logic [1:0]  wave;
  logic [1:0]  pin;
  int          bad_count = 0;
  int          compares = 0;

  // 25 MHz system clock
  always #20 i_clk = ~i_clk;

  tmoc_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
    .i_tick(tick), .i_capture_value(16'h0000), .i_irq_ack(ack), .o_irq(irq),
    .i_port(port), .o_pin_out(pin_out), .o_pin_oe_n(oe_n), .o_waveform_out(wave));

  tmoc_port_model u_port (.i_dir(dir), .i_out(pout), .i_pin_out(pin_out),
    .i_pin_oe_n(oe_n), .o_port(port), .o_pin(pin));

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one write cycle, optionally beside a timer tick
  task automatic wr(logic [3:0] a, logic [7:0] d, logic t = 1'b0);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    tick <= t;
    @(posedge i_clk);
    bus.wr <= 1'b0;
    tick <= 1'b0;
  endtask

  // high byte first, then low byte
  task automatic wr16(logic [3:0] a, logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask

  // read data sampled in the cycle after the strobe only
  task automatic rd(logic [3:0] a);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic step();
    @(posedge i_clk);
    tick <= 1'b1;
    @(posedge i_clk);
    tick <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    chk("wave", 16'(wave), 16'h0);
    chk("irq", 16'(irq), 16'h0);
    chk("pin_out", 16'(pin_out), 16'h2);
    chk("pin", 16'(pin), 16'h3);
    $display("test reset done");
  endtask

  task automatic t_force();
    wr(`TMOC_OFS_CTRL_A, 8'hD0); // a set, b toggle, normal mode
    wr(`TMOC_OFS_CTRL_B, 8'h03);
    #1 chk("wave", 16'(wave), 16'h3);
    rd(`TMOC_OFS_FLAGS);
    chk("flags", 16'(got), 16'h0);
    @(posedge i_clk);
    dir <= 2'h3;
    @(posedge i_clk);
    #1 chk("pin", 16'(pin), 16'h3);
    wr(`TMOC_OFS_CTRL_A, 8'h00);
    wr(`TMOC_OFS_CTRL_B, 8'h02);
    #1 chk("wave", 16'(wave), 16'h3);
    chk("pin", 16'(pin), 16'h2);
    $display("test force done");
  endtask

  task automatic t_match();
    wr(`TMOC_OFS_CTRL_A, 8'h40); // a toggles, b none
    wr16(`TMOC_OFS_CMPA_LO, 16'h1205);
    wr16(`TMOC_OFS_CNT_LO, 16'h1205);
    step();
    rd(`TMOC_OFS_FLAGS);
    chk("blocked", 16'(got), 16'h0);
    wr16(`TMOC_OFS_CNT_LO, 16'h1204);
    step();
    step();
    rd(`TMOC_OFS_FLAGS);
    chk("flags", 16'(got), 16'h1);
    chk("wave", 16'(wave), 16'h2);
    wr(`TMOC_OFS_CNT_HI, 8'h77);
    rd(`TMOC_OFS_CMPA_HI);
    chk("cmp_hi", 16'(got), 16'h12);
    wr(`TMOC_OFS_CTRL_B, 8'h04);
    #1 chk("irq", 16'(irq), 16'h1);
    @(posedge i_clk);
    ack <= 3'h1;
    @(posedge i_clk);
    ack <= 3'h0;
    #1 chk("irq", 16'(irq), 16'h0);
    $display("test match done");
  endtask

  task automatic t_ovf();
    wr(`TMOC_OFS_CTRL_B, 8'h10);
    wr(`TMOC_OFS_CNT_HI, 8'hFF);
    wr(`TMOC_OFS_CNT_LO, 8'hFF, 1'b1);
    rd(`TMOC_OFS_CNT_LO);
    chk("cnt_lo", 16'(got), 16'hFF);
    rd(`TMOC_OFS_FLAGS);
    chk("flags", 16'(got), 16'h0);
    step();
    chk("irq", 16'(irq), 16'h4);
    rd(`TMOC_OFS_CNT_LO);
    chk("cnt_lo", 16'(got), 16'h0);
    wr(`TMOC_OFS_FLAGS, 8'h04);
    #1 chk("irq", 16'(irq), 16'h0);
    $display("test overflow done");
  endtask

  task automatic t_buffer();
    wr16(`TMOC_OFS_CMPB_LO, 16'h0020);
    wr(`TMOC_OFS_CTRL_A, 8'h45); // fast pwm, top 0x00FF
    #1 chk("wave", 16'(wave), 16'h2);
    wr(`TMOC_OFS_CTRL_B, 8'h01);
    #1 chk("wave", 16'(wave), 16'h2);
    wr16(`TMOC_OFS_CMPB_LO, 16'h0010);
    rd(`TMOC_OFS_CMPB_LO);
    chk("buf_lo", 16'(got), 16'h10);
    wr16(`TMOC_OFS_CNT_LO, 16'h000F);
    step();
    step();
    rd(`TMOC_OFS_FLAGS);
    chk("flags", 16'(got[1:0]), 16'h0);
    wr16(`TMOC_OFS_CNT_LO, 16'h00FE);
    step();
    step();
    wr16(`TMOC_OFS_CNT_LO, 16'h000F);
    step();
    step();
    rd(`TMOC_OFS_FLAGS);
    chk("flags", 16'(got[1:0]), 16'h2);
    wr16(`TMOC_OFS_CMPA_LO, 16'h0008);
    wr(`TMOC_OFS_CTRL_A, 8'h4F); // top from compare a
    wr16(`TMOC_OFS_CNT_LO, 16'h1204);
    step();
    step();
    rd(`TMOC_OFS_CNT_LO);
    chk("cnt_top", 16'(got), 16'h0);
    wr16(`TMOC_OFS_CNT_LO, 16'h0008);
    step();
    rd(`TMOC_OFS_CNT_LO);
    chk("cnt_past", 16'(got), 16'h9);
    $display("test buffer done");
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // cut a hang short well past the expected run
  initial begin
    repeat (5000) @(posedge i_clk);
    bad_count++;
    $display("ERROR watchdog expected done seen timeout");
    finish_test();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1 t_reset();
    t_force();
    t_match();
    t_ovf();
    t_buffer();
    finish_test();
  end
endmodule
